// *** pkg/ces_pkg.sv ***
package ces_pkg;

  // Register byte offsets
  localparam logic [5:0] OFS_CTRL       = 6'h00;
  localparam logic [5:0] OFS_STATE      = 6'h04;
  localparam logic [5:0] OFS_LAST_FATAL = 6'h08;
  localparam logic [5:0] OFS_TALLY      = 6'h0C;
  localparam logic [5:0] OFS_SPECIAL    = 6'h10;
  localparam logic [5:0] OFS_IRQ_STAT   = 6'h14;
  localparam logic [5:0] OFS_IRQ_MASK   = 6'h18;
  localparam logic [5:0] OFS_CFG_STORED = 6'h1C;
  localparam logic [5:0] OFS_IO_STATUS  = 6'h20;
  localparam logic [5:0] OFS_ERR_CODE   = 6'h24;

  // Control register fields
  localparam int CTRL_RESTART_BIT = 0;
  localparam int CTRL_MEMCLR_BIT  = 1;

  // Special memory error bits; event bits share this layout plus fatal
  localparam int SM_RUNTIME = 0;
  localparam int SM_POINTER = 1;
  localparam int SM_CFG     = 2;
  localparam int SM_COMPILE = 3;
  localparam int SM_W       = 4;
  localparam int EV_FATAL   = 4;
  localparam int EV_W       = 5;

  // Error codes reported to software
  localparam logic [7:0] CODE_NONE      = 8'h00;
  localparam logic [7:0] CODE_DIAG_FAIL = 8'h01;
  localparam logic [7:0] CODE_COMPILE   = 8'h02;
  localparam logic [7:0] CODE_POINTER   = 8'h03;
  localparam logic [7:0] CODE_RUNTIME   = 8'h04;
  localparam logic [7:0] CODE_CFG       = 8'h05;

  // Timing
  localparam int CLK_MHZ          = 25;
  localparam int DIAG_TIME_US     = 10;
  localparam int REFRESH_TIME_US  = 100;
  localparam int DIAG_CYCLES      = DIAG_TIME_US * CLK_MHZ;
  localparam int REFRESH_CYCLES   = REFRESH_TIME_US * CLK_MHZ;
  localparam int CNT_W            = 12;

  // Mode selector encoding
  localparam logic [1:0] MODE_STOP   = 2'h0;
  localparam logic [1:0] MODE_RUN    = 2'h1;
  localparam logic [1:0] MODE_REMOTE = 2'h2;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    ST_DIAG  = 2'b00,
    ST_RUN   = 2'b01,
    ST_STOP  = 2'b10,
    ST_FATAL = 2'b11
  } ces_state_type;

endpackage

// *** verilog/ces_sync.sv ***
`timescale 1ns/100ps
module ces_sync
  import ces_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1;

  // Two flops; only the second stage leaves this module
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= '0;
      dout   <= '0;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule

// *** verilog/ces_supervisor.sv ***
// Summary of operation
// - Fatal error halts program, enters stop, lights fault and stop, outputs off.
// - Fatal stop condition holds until a restart occurs.
// - Restart on power cycle, run/remote to stop switch, or host reset command.
// - Restart clears fatal and runs diagnostics; failure sets fault again, else resumes.
// - Last fatal code kept readable while RAM is retained.
// - Last fatal code cleared on full memory clear or RAM loss.
// - Fatal tally since last full clear kept while RAM is retained.
// - Fatal tally zeroed on full memory clear or RAM loss.
// - Non-fatal errors in run are reflected in readable special memory bits.
// - At startup the I/O configuration is stored in system data and special memory.
// - In normal operation the I/O status in special memory is refreshed periodically.
// - Configuration mismatch sets changed flag and stops module updates.
// - Changed flag clears only when I/O matches stored configuration again.
// - Compile violation aborts download, reports a code, keeps old program.
// - Pointer out of range is a non-fatal run-time error, recorded for host.
// - Non-fatal errors never stop; logged in special memory, execution continues.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ces_supervisor
  import ces_pkg::*;
#(
  parameter int IO_W    = 8,
  parameter int TALLY_W = 16
)
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [5:0]      awaddr,
  input  wire logic            awvalid,
  output logic                 awready,
  input  wire logic [31:0]     wdata,
  input  wire logic [3:0]      wstrb,
  input  wire logic            wvalid,
  output logic                 wready,
  output logic [1:0]           bresp,
  output logic                 bvalid,
  input  wire logic            bready,
  input  wire logic [5:0]      araddr,
  input  wire logic            arvalid,
  output logic                 arready,
  output logic [31:0]          rdata,
  output logic [1:0]           rresp,
  output logic                 rvalid,
  input  wire logic            rready,
  input  wire logic [1:0]      mode_sel,
  input  wire logic            power_cycle,
  input  wire logic            ram_lost,
  input  wire logic            diag_fail,
  input  wire logic [IO_W-1:0] io_config,
  input  wire logic            fatal_event,
  input  wire logic [7:0]      fatal_code,
  input  wire logic            runtime_err,
  input  wire logic            pointer_err,
  input  wire logic            dl_done,
  input  wire logic            dl_violation,
  output logic                 outputs_enable,
  output logic                 fault_led,
  output logic                 stop_led,
  output logic                 program_run,
  output logic                 module_update_en,
  output logic                 program_commit,
  output logic                 download_abort,
  output logic                 irq
);

  localparam int SYNC_W = IO_W + 5;
  localparam logic [CNT_W-1:0] DIAG_LOAD    = CNT_W'(DIAG_CYCLES - 1);
  localparam logic [CNT_W-1:0] REFRESH_LOAD = CNT_W'(REFRESH_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [SYNC_W-1:0] sync_out;
  logic [1:0]        mode_s;
  logic              power_s;
  logic              ram_lost_s;
  logic              diag_fail_s;
  logic [IO_W-1:0]   io_cfg_s;

  ces_sync #(.W(SYNC_W)) u_sync
  (
    .clk  (clk),
    .rst  (rst),
    .din  ({mode_sel, power_cycle, ram_lost, diag_fail, io_config}),
    .dout (sync_out)
  );

  assign {mode_s, power_s, ram_lost_s, diag_fail_s, io_cfg_s} = sync_out;

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic        aw_full;
  logic        w_full;
  logic [5:0]  wr_addr;
  logic [31:0] wr_data;
  logic        wr_lane0;
  logic        next_aw_full;
  logic        next_w_full;
  logic [5:0]  next_wr_addr;
  logic [31:0] next_wr_data;
  logic        next_wr_lane0;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        wr_fire;
  logic        wr_ok;
  logic        map_wr;
  logic        map_rd;
  logic [31:0] rd_mux;

  // State registers used by the read mux
  ces_state_type        state;
  logic [7:0]           last_fatal;
  logic [TALLY_W-1:0]   tally;
  logic [IO_W-1:0]      cfg_stored;
  logic [SM_W-1:0]      special_memory;
  logic [IO_W-1:0]      io_status;
  logic [EV_W-1:0]      irq_stat;
  logic [EV_W-1:0]      irq_mask;
  logic [7:0]           err_code;

  assign awready = !aw_full;
  assign wready  = !w_full;
  assign arready = !rvalid;
  // Both halves held and no answer pending; a pending answer stalls new writes
  assign wr_fire = aw_full && w_full && !bvalid;
  assign map_wr  = (wr_addr == OFS_CTRL) || (wr_addr == OFS_SPECIAL) ||
                   (wr_addr == OFS_IRQ_STAT) || (wr_addr == OFS_IRQ_MASK);
  assign wr_ok   = wr_fire && map_wr && wr_lane0;

  // Read decode; unmapped addresses answer SLVERR with zero data
  always_comb
  begin
    map_rd = 1'b1;
    rd_mux = 32'h0000_0000;
    case (araddr)
      OFS_CTRL       : rd_mux = 32'h0000_0000;
      OFS_STATE      : rd_mux = 32'(state);
      OFS_LAST_FATAL : rd_mux = 32'(last_fatal);
      OFS_TALLY      : rd_mux = 32'(tally);
      OFS_SPECIAL    : rd_mux = 32'(special_memory);
      OFS_IRQ_STAT   : rd_mux = 32'(irq_stat);
      OFS_IRQ_MASK   : rd_mux = 32'(irq_mask);
      OFS_CFG_STORED : rd_mux = 32'(cfg_stored);
      OFS_IO_STATUS  : rd_mux = 32'(io_status);
      OFS_ERR_CODE   : rd_mux = 32'(err_code);
      default        : map_rd = 1'b0;
    endcase
  end

  // Bus next-state
  always_comb
  begin
    next_aw_full  = aw_full;
    next_w_full   = w_full;
    next_wr_addr  = wr_addr;
    next_wr_data  = wr_data;
    next_wr_lane0 = wr_lane0;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    next_rvalid   = rvalid;
    next_rdata    = rdata;
    next_rresp    = rresp;
    if (awvalid && !aw_full)
    begin
      next_aw_full = 1'b1;
      next_wr_addr = {awaddr[5:2], 2'b00};
    end
    if (wvalid && !w_full)
    begin
      next_w_full   = 1'b1;
      next_wr_data  = wdata;
      next_wr_lane0 = wstrb[0];
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (wr_fire)
    begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = map_wr ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid && rready)
      next_rvalid = 1'b0;
    if (arvalid && !rvalid)
    begin
      next_rvalid = 1'b1;
      next_rdata  = rd_mux;
      next_rresp  = map_rd ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_full  <= 1'b0;
      w_full   <= 1'b0;
      wr_addr  <= 6'h00;
      wr_data  <= 32'h0000_0000;
      wr_lane0 <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      rvalid   <= 1'b0;
      rdata    <= 32'h0000_0000;
      rresp    <= RESP_OKAY;
    end
    else
    begin
      aw_full  <= next_aw_full;
      w_full   <= next_w_full;
      wr_addr  <= next_wr_addr;
      wr_data  <= next_wr_data;
      wr_lane0 <= next_wr_lane0;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      rvalid   <= next_rvalid;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operating state, diagnostics and fatal records

  ces_state_type      next_state;
  logic [CNT_W-1:0]   diag_cnt;
  logic [CNT_W-1:0]   next_diag_cnt;
  logic [1:0]         mode_prev;
  logic               power_prev;
  logic [7:0]         next_last_fatal;
  logic [TALLY_W-1:0] next_tally;
  logic [IO_W-1:0]    next_cfg_stored;
  logic               restart;
  logic               mem_clear;
  logic               mode_active;
  logic               fatal_now;
  logic               diag_done;

  assign mode_active = (mode_s == MODE_RUN) || (mode_s == MODE_REMOTE);
  // Power rise, switch to stop from run/remote, or host command
  assign restart   = (power_s && !power_prev) ||
                     (((mode_prev == MODE_RUN) || (mode_prev == MODE_REMOTE)) && (mode_s == MODE_STOP)) ||
                     (wr_ok && (wr_addr == OFS_CTRL) && wr_data[CTRL_RESTART_BIT]);
  // Full clear by software, or RAM not kept over the outage
  assign mem_clear = (wr_ok && (wr_addr == OFS_CTRL) && wr_data[CTRL_MEMCLR_BIT]) ||
                     (power_s && !power_prev && ram_lost_s);
  assign diag_done = (state == ST_DIAG) && (diag_cnt == '0) && !restart;
  assign fatal_now = (state != ST_FATAL) && !restart &&
                     (fatal_event || (diag_done && diag_fail_s));

  always_comb
  begin
    next_state      = state;
    next_diag_cnt   = diag_cnt;
    next_last_fatal = last_fatal;
    next_tally      = tally;
    next_cfg_stored = cfg_stored;
    if (mem_clear)
    begin
      next_last_fatal = CODE_NONE;
      next_tally      = '0;
    end
    if (restart)
    begin
      // Fatal is dropped here; diagnostics decide whether it comes back
      next_state    = ST_DIAG;
      next_diag_cnt = DIAG_LOAD;
    end
    else if (fatal_now)
    begin
      next_state      = ST_FATAL;
      next_last_fatal = fatal_event ? fatal_code : CODE_DIAG_FAIL;
      next_tally      = tally + 1'b1;
    end
    else
    begin
      case (state)
        ST_DIAG :
        begin
          if (diag_cnt != '0)
            next_diag_cnt = diag_cnt - 1'b1;
          else
          begin
            next_cfg_stored = io_cfg_s;
            next_state      = mode_active ? ST_RUN : ST_STOP;
          end
        end
        ST_RUN   : next_state = mode_active ? ST_RUN : ST_STOP;
        ST_STOP  : next_state = mode_active ? ST_RUN : ST_STOP;
        ST_FATAL : next_state = ST_FATAL;
        default  : next_state = ST_DIAG;
      endcase
    end
  end

  // Power-up enters diagnostics; records start empty after a true reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state          <= ST_DIAG;
      diag_cnt       <= DIAG_LOAD;
      mode_prev      <= MODE_STOP;
      power_prev     <= 1'b0;
      last_fatal     <= CODE_NONE;
      tally          <= '0;
      cfg_stored     <= '0;
      outputs_enable <= 1'b0;
      fault_led      <= 1'b0;
      stop_led       <= 1'b1;
      program_run    <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      diag_cnt       <= next_diag_cnt;
      mode_prev      <= mode_s;
      power_prev     <= power_s;
      last_fatal     <= next_last_fatal;
      tally          <= next_tally;
      cfg_stored     <= next_cfg_stored;
      outputs_enable <= (next_state == ST_RUN);
      fault_led      <= (next_state == ST_FATAL);
      stop_led       <= (next_state != ST_RUN);
      program_run    <= (next_state == ST_RUN);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Non-fatal logging, I/O refresh, download checks, interrupts

  logic [SM_W-1:0]  next_special_memory;
  logic [IO_W-1:0]  next_io_status;
  logic [CNT_W-1:0] refresh_cnt;
  logic [CNT_W-1:0] next_refresh_cnt;
  logic [7:0]       next_err_code;
  logic [EV_W-1:0]  next_irq_stat;
  logic [EV_W-1:0]  next_irq_mask;
  logic [EV_W-1:0]  events;
  logic             dl_bad;
  logic             next_dl_bad;
  logic             refresh_tick;
  logic             in_run;
  logic             w1c_sm;
  logic             w1c_irq;

  assign in_run       = (state == ST_RUN);
  assign refresh_tick = (state != ST_DIAG) && (refresh_cnt == '0);
  assign w1c_sm       = wr_ok && (wr_addr == OFS_SPECIAL);
  assign w1c_irq      = wr_ok && (wr_addr == OFS_IRQ_STAT);

  always_comb
  begin
    next_special_memory = special_memory;
    next_io_status      = io_status;
    next_refresh_cnt    = refresh_cnt;
    next_err_code       = err_code;
    next_irq_mask       = irq_mask;
    next_dl_bad         = dl_bad;
    events              = '0;
    // Software clear first so that a same-cycle hardware set wins
    if (w1c_sm)
    begin
      next_special_memory[SM_RUNTIME] = special_memory[SM_RUNTIME] & ~wr_data[SM_RUNTIME];
      next_special_memory[SM_POINTER] = special_memory[SM_POINTER] & ~wr_data[SM_POINTER];
      next_special_memory[SM_COMPILE] = special_memory[SM_COMPILE] & ~wr_data[SM_COMPILE];
    end
    if (wr_ok && (wr_addr == OFS_IRQ_MASK))
      next_irq_mask = wr_data[EV_W-1:0];
    // Run-time errors only logged while running; program keeps going
    if (in_run && runtime_err)
    begin
      next_special_memory[SM_RUNTIME] = 1'b1;
      next_err_code                   = CODE_RUNTIME;
      events[SM_RUNTIME]              = 1'b1;
    end
    if (in_run && pointer_err)
    begin
      next_special_memory[SM_POINTER] = 1'b1;
      next_err_code                   = CODE_POINTER;
      events[SM_POINTER]              = 1'b1;
    end
    // Periodic sample; a mismatch freezes module updates until it matches again
    if (state == ST_DIAG)
    begin
      next_refresh_cnt = REFRESH_LOAD;
      next_io_status   = io_cfg_s;
    end
    else if (refresh_tick)
    begin
      next_refresh_cnt = REFRESH_LOAD;
      next_io_status   = io_cfg_s;
      if (io_cfg_s != cfg_stored)
      begin
        next_special_memory[SM_CFG] = 1'b1;
        events[SM_CFG]              = !special_memory[SM_CFG];
        next_err_code               = special_memory[SM_CFG] ? err_code : CODE_CFG;
      end
      else
        next_special_memory[SM_CFG] = 1'b0;
    end
    else
      next_refresh_cnt = refresh_cnt - 1'b1;
    // A violation poisons the whole download; the stored program is not touched
    if (dl_violation)
    begin
      next_dl_bad                     = 1'b1;
      next_special_memory[SM_COMPILE] = 1'b1;
      next_err_code                   = CODE_COMPILE;
      events[SM_COMPILE]              = !dl_bad;
    end
    if (dl_done)
      next_dl_bad = 1'b0;
    events[EV_FATAL] = fatal_now;
    next_irq_stat    = (irq_stat & ~(w1c_irq ? wr_data[EV_W-1:0] : '0)) | events;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      special_memory   <= '0;
      io_status        <= '0;
      refresh_cnt      <= REFRESH_LOAD;
      err_code         <= CODE_NONE;
      irq_stat         <= '0;
      irq_mask         <= '0;
      dl_bad           <= 1'b0;
      program_commit   <= 1'b0;
      download_abort   <= 1'b0;
      module_update_en <= 1'b0;
      irq              <= 1'b0;
    end
    else
    begin
      special_memory   <= next_special_memory;
      io_status        <= next_io_status;
      refresh_cnt      <= next_refresh_cnt;
      err_code         <= next_err_code;
      irq_stat         <= next_irq_stat;
      irq_mask         <= next_irq_mask;
      dl_bad           <= next_dl_bad;
      // Commit only a clean download; otherwise the old program stays
      program_commit   <= dl_done && !dl_bad && !dl_violation;
      download_abort   <= dl_violation && !dl_bad;
      module_update_en <= (next_state == ST_RUN) && !next_special_memory[SM_CFG];
      irq              <= |(next_irq_stat & next_irq_mask);
    end
  end

endmodule

// *** test/ces_supervisor_properties.sv ***
`timescale 1ns/100ps
module ces_supervisor_checker
  import ces_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic power_cycle,
  input wire logic fatal_event,
  input wire logic runtime_err,
  input wire logic pointer_err,
  input wire logic dl_done,
  input wire logic dl_violation,
  input wire logic outputs_enable,
  input wire logic fault_led,
  input wire logic stop_led,
  input wire logic program_run,
  input wire logic module_update_en,
  input wire logic program_commit,
  input wire logic download_abort
);
  logic [8:0] low_cnt;
  logic [8:0] next_low_cnt;

  // Cycles out of run; saturates so a long fatal stay cannot wrap
  always_comb
    next_low_cnt = program_run ? 9'h000 : ((low_cnt == 9'h1FF) ? low_cnt : low_cnt + 9'h001);
  always_ff @(posedge clk or posedge rst)
    if (rst)
      low_cnt <= 9'h000;
    else
      low_cnt <= next_low_cnt;

  //////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Fatal in run, then the safe stop picture
  sequence fatal_in_run;
    fatal_event && program_run;
  endsequence
  sequence safe_stop;
    !outputs_enable && fault_led && stop_led && !program_run;
  endsequence

  a_fatal_stop: assert property (fatal_in_run |=> ##1 safe_stop)
    else $error("fatal without safe stop");
  a_fault_safe: assert property (fault_led |-> safe_stop)
    else $error("fault lit without safe stop");
  a_stop_led: assert property (stop_led == !program_run)
    else $error("stop led wrong");
  a_outputs_run: assert property (outputs_enable == program_run)
    else $error("outputs enabled outside run");
  a_nonfatal_runs: assert property ((runtime_err || pointer_err || dl_violation) && program_run
    && !fatal_event |=> program_run)
    else $error("non-fatal error left run");
  a_abort_cause: assert property (download_abort |-> $past(dl_violation))
    else $error("stray abort");
  a_commit_clean: assert property (program_commit |-> $past(dl_done) && !$past(dl_violation))
    else $error("bad commit");
  a_update_run: assert property (module_update_en |-> program_run)
    else $error("update outside run");
  a_restart_diag: assert property ($rose(power_cycle) |-> ##[1:6] !program_run)
    else $error("no restart");
  a_diag_length: assert property ($rose(program_run) |-> low_cnt >= 9'h0F8)
    else $error("diagnostics cut short");
endmodule

bind ces_supervisor ces_supervisor_checker u_chk (.clk(clk), .rst(rst), .power_cycle(power_cycle),
  .fatal_event(fatal_event), .runtime_err(runtime_err), .pointer_err(pointer_err), .dl_done(dl_done),
  .dl_violation(dl_violation), .outputs_enable(outputs_enable), .fault_led(fault_led),
  .stop_led(stop_led), .program_run(program_run), .module_update_en(module_update_en),
  .program_commit(program_commit), .download_abort(download_abort));

// *** test/ces_io_model.sv ***
`timescale 1ns/100ps
module ces_io_model
(
  input  wire logic       clk,
  input  wire logic       swap,
  output logic      [7:0] io_config
);
  // Alternate set differs in one point, like a swapped card
  localparam logic [7:0] BASE = 8'h3C;
  localparam logic [7:0] ALT  = 8'h3D;

  initial io_config = BASE;
  // Changes just after an edge
  always @(posedge clk)
    io_config <= swap ? ALT : BASE;
endmodule

// *** test/test_ces_supervisor.sv ***
`timescale 1ns/100ps
module test_ces_supervisor
  import ces_pkg::*;
;
  typedef struct {logic wr; logic [5:0] a; logic [31:0] e; logic [1:0] r;} ces_row_type;
  logic        clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, power_cycle = 1'b0, ram_lost = 1'b0;
  logic        diag_fail = 1'b0, fatal_event = 1'b0, runtime_err = 1'b0, pointer_err = 1'b0;
  logic        dl_done = 1'b0, dl_violation = 1'b0, swap = 1'b0;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  mode_sel = MODE_RUN, bresp, rresp;
  logic [7:0]  fatal_code = 8'h00, io_config;
  logic        awready, wready, bvalid, arready, rvalid, outputs_enable, fault_led, stop_led;
  logic        program_run, module_update_en, program_commit, download_abort, irq;
  int          num_errors = 0, checks_done = 0, cycles = 0, n_abort = 0, n_commit = 0;
  // Values after boot; e is the data of a write row
  ces_row_type rows [12] = '{'{1'b0, OFS_STATE, 32'h1, RESP_OKAY},
    '{1'b0, OFS_LAST_FATAL, 32'h0, RESP_OKAY}, '{1'b0, OFS_TALLY, 32'h0, RESP_OKAY},
    '{1'b0, OFS_SPECIAL, 32'h0, RESP_OKAY}, '{1'b0, OFS_CFG_STORED, 32'h3C, RESP_OKAY},
    '{1'b0, OFS_IO_STATUS, 32'h3C, RESP_OKAY}, '{1'b0, OFS_ERR_CODE, 32'h0, RESP_OKAY},
    '{1'b1, OFS_TALLY, 32'h5, RESP_SLVERR}, '{1'b0, OFS_TALLY, 32'h0, RESP_OKAY},
    '{1'b1, 6'h3C, 32'h1, RESP_SLVERR}, '{1'b0, 6'h3C, 32'h0, RESP_SLVERR},
    '{1'b0, OFS_CTRL, 32'h0, RESP_OKAY}};

  always #20 clk = ~clk;

  ces_supervisor u_dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .mode_sel(mode_sel), .power_cycle(power_cycle),
    .ram_lost(ram_lost), .diag_fail(diag_fail), .io_config(io_config), .fatal_event(fatal_event),
    .fatal_code(fatal_code), .runtime_err(runtime_err), .pointer_err(pointer_err), .dl_done(dl_done),
    .dl_violation(dl_violation), .outputs_enable(outputs_enable), .fault_led(fault_led),
    .stop_led(stop_led), .program_run(program_run), .module_update_en(module_update_en),
    .program_commit(program_commit), .download_abort(download_abort), .irq(irq));
  ces_io_model u_io (.clk(clk), .swap(swap), .io_config(io_config));

  //////////////////////////////////////////////////////////////
  task finish_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk_word(input logic [31:0] v, input logic [31:0] e);
    checks_done++;
    if (v !== e)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, v, e);
    end
  endtask
  task chk_flag(input logic v, input logic e);
    chk_word({31'h0, v}, {31'h0, e});
  endtask
  task chk_resp(input logic [1:0] v, input logic [1:0] e);
    chk_word({30'h0, v}, {30'h0, e});
  endtask
  // One-cycle pulses counted on every edge
  always @(posedge clk)
  begin
    cycles++;
    n_commit += (program_commit === 1'b1);
    n_abort += (download_abort === 1'b1);
    if (cycles == 60000)
    begin
      chk_flag(1'b0, 1'b1);
      finish_test;
    end
  end
  // Each half dropped after the edge that takes it; only the timeout ends a wait
  task axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk_resp(bresp, er);
    @(posedge clk);
  endtask
  task axi_rd(input logic [5:0] a, output logic [31:0] d, input logic [1:0] er);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    rready <= 1'b0;
    chk_resp(rresp, er);
    @(posedge clk);
  endtask
  task rd_chk(input logic [5:0] a, input logic [31:0] e);
    axi_rd(a, rd, RESP_OKAY);
    chk_word(rd, e);
  endtask
  task rec(input logic [31:0] st, lf, ta);
    rd_chk(OFS_STATE, st);
    rd_chk(OFS_LAST_FATAL, lf);
    rd_chk(OFS_TALLY, ta);
  endtask
  task fatal(input logic [7:0] c);
    fatal_code <= c; fatal_event <= 1'b1;
    @(posedge clk);
    fatal_event <= 1'b0;
    @(posedge clk);
  endtask
  // 250 diagnostic cycles plus sync; 300 leaves margin
  task pwr;
    power_cycle <= 1'b1;
    repeat (5) @(posedge clk);
    power_cycle <= 1'b0;
    repeat (300) @(posedge clk);
  endtask

  //////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (300) @(posedge clk);
    for (int i = 0; i < 12; i++)
      if (rows[i].wr)
        axi_wr(rows[i].a, rows[i].e, rows[i].r);
      else
      begin
        axi_rd(rows[i].a, rd, rows[i].r);
        chk_word(rd, rows[i].e);
      end
    // Non-fatal errors in run, interrupts masked
    pointer_err <= 1'b1;
    @(posedge clk);
    pointer_err <= 1'b0; runtime_err <= 1'b1;
    @(posedge clk);
    runtime_err <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(OFS_SPECIAL, 32'h3);
    rd_chk(OFS_ERR_CODE, {24'h0, CODE_RUNTIME});
    @(negedge clk);
    chk_flag(program_run, 1'b1);
    chk_flag(irq, 1'b0);
    @(posedge clk);
    axi_wr(OFS_IRQ_MASK, 32'h1F, RESP_OKAY);
    chk_flag(irq, 1'b1);
    axi_wr(OFS_IRQ_STAT, 32'h1F, RESP_OKAY);
    axi_wr(OFS_SPECIAL, 32'hB, RESP_OKAY);
    chk_flag(irq, 1'b0);
    // Broken download, then a clean one
    dl_violation <= 1'b1;
    @(posedge clk);
    dl_violation <= 1'b0; dl_done <= 1'b1;
    repeat (2) @(posedge clk);
    dl_done <= 1'b0;
    repeat (3) @(posedge clk);
    chk_word(n_abort, 32'h1);
    chk_word(n_commit, 32'h1);
    rd_chk(OFS_ERR_CODE, {24'h0, CODE_COMPILE});
    // Rack change and return
    swap <= 1'b1;
    repeat (2600) @(posedge clk);
    chk_flag(module_update_en, 1'b0);
    chk_flag(program_run, 1'b1);
    axi_rd(OFS_SPECIAL, rd, RESP_OKAY);
    chk_word(rd & 32'h4, 32'h4);
    rd_chk(OFS_IO_STATUS, 32'h3D);
    swap <= 1'b0;
    repeat (2600) @(posedge clk);
    chk_flag(module_update_en, 1'b1);
    // Fatal, held, three restart kinds
    fatal(8'hA5);
    @(negedge clk);
    chk_flag(fault_led, 1'b1);
    chk_flag(outputs_enable, 1'b0);
    @(posedge clk);
    fatal(8'h77);
    repeat (300) @(posedge clk);
    chk_flag(fault_led, 1'b1);
    rec(32'h3, 32'hA5, 32'h1);
    axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
    repeat (300) @(posedge clk);
    chk_flag(fault_led, 1'b0);
    rec(32'h1, 32'hA5, 32'h1);
    fatal(8'h5A);
    mode_sel <= MODE_STOP;
    repeat (300) @(posedge clk);
    rec(32'h2, 32'h5A, 32'h2);
    mode_sel <= MODE_REMOTE;
    pwr;
    rec(32'h1, 32'h5A, 32'h2);
    diag_fail <= 1'b1;
    pwr;
    rec(32'h3, {24'h0, CODE_DIAG_FAIL}, 32'h3);
    diag_fail <= 1'b0; ram_lost <= 1'b1;
    repeat (5) @(posedge clk);
    pwr;
    ram_lost <= 1'b0;
    rec(32'h1, 32'h0, 32'h0);
    fatal(8'h33);
    axi_wr(OFS_CTRL, 32'h2, RESP_OKAY);
    rec(32'h3, 32'h0, 32'h0);
    finish_test;
  end
endmodule
